// >>> hw/i2c_engine_pkg.sv
// constants, carrier structs and state types of the two-wire master byte engine
package i2c_engine_pkg;

  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_BUFFER = 8'h00;
  localparam logic [7:0] ADDR_CONTROL = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_RATE = 8'h0c;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned CTL_STOP = 0;
  localparam int unsigned CTL_RECV = 1;
  localparam int unsigned CTL_ACKSEQ = 2;
  localparam int unsigned CTL_ACKVAL = 3;
  localparam int unsigned STA_BF = 0;
  localparam int unsigned STA_IF = 1;
  localparam int unsigned STA_ACK_STATUS_BIT = 2;
  localparam int unsigned STA_WRITE_COLLISION_FLAG = 3;
  localparam int unsigned STA_OVF = 4;
  localparam int unsigned STA_STOPDET = 5;

  // ----------------------------------------------------------------
  // reset values and counts
  // ----------------------------------------------------------------
  // 125 cycles per half bit at 25 MHz gives a 100 kHz bus
  localparam logic [7:0] RATE_RESET = 8'h7c;
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;
  localparam logic [3:0] ACK_BIT = 4'h8;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_s;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } wb_rsp_s;

  typedef struct packed {
    logic sclOut;
    logic sclOe;
    logic sdaOut;
    logic sdaOe;
  } pin_out_s;

  typedef enum logic [3:0] {
    IDLE, TX_LOW, TX_HIGH, RX_LOW, RX_HIGH, ACK_LOW, ACK_HIGH,
    STOP_SDA, STOP_COUNT, STOP_SCLHI, STOP_SDAHI, STOP_DONE
  } engine_state_e;

  typedef struct packed {
    engine_state_e st;
    logic [7:0] cnt;
    logic [3:0] bitIdx;
    logic [7:0] shift;
    logic [7:0] xferBuf;
    logic [7:0] rate;
    logic bf;
    logic pif;
    logic ack_status_bit;
    logic write_collision_flag;
    logic ovf;
    logic stopDet;
    logic stopReq;
    logic rxReq;
    logic ackReq;
    logic ackVal;
    logic sclLow;
    logic sdaLow;
    logic sclMeta;
    logic sclS;
    logic sdaMeta;
    logic sdaS;
    logic ack;
    logic [7:0] rdat;
  } engine_s;

endpackage

// >>> hw/i2c_master_byte_engine.sv
// two-wire master byte engine: transmit, receive, acknowledge and stop
`timescale 1ns/1ps
`default_nettype none

// How it works
// RL1: idle buffer write sets buffer full and starts the bit clock
// RL2: data changes only with clock low; low and high each last one period
// RL3: address bytes go out as seven bits plus direction, sent immediately
// RL4: falling edge of clock eight clears buffer full and releases data
// RL5: ninth clock samples data into the acknowledge status bit
// RL6: after clock nine raise interrupt flag, park clock low, data released
// RL7: buffer write while busy is dropped and sets write collision
// RL8: software clears write collision before the next transmission
// RL9: software starts, waits for interrupt, clears it, then loads address
// RL10: stop ends a transfer; interrupt flag rises when it completes
// RL11: receive request is taken only while the engine is idle
// RL12: receiving toggles clock each rollover and shifts data in
// RL13: after eighth received clock: clear request, load buffer, flag, idle
// RL14: receive sets buffer full; reading the buffer clears it
// RL15: byte completed while buffer still full sets overflow
// RL16: software reads each byte, picks acknowledge, then ends with nack/stop
// RL17: acknowledge value bit decides what the master drives on data
// RL18: acknowledge: clock low with value, one period, release, one period
// RL19: acknowledge end clears its request, stops counter, returns idle
// RL20: stop: data low, count after seen low, release clock, then data
// RL21: data seen high with clock high flags stop; period later interrupt
// RL22: counter reloads while released clock is still seen low, counts once seen high
// RL23: bytes move most significant bit first
module i2c_master_byte_engine (
  input wire logic clk,
  input wire logic nrst,
  input wire i2c_engine_pkg::wb_req_s wbReq,
  output var i2c_engine_pkg::wb_rsp_s wbRsp,
  input wire logic sclIn,
  input wire logic sdaIn,
  output var i2c_engine_pkg::pin_out_s pins
);
  import i2c_engine_pkg::*;

  engine_s q;
  engine_s d;
  logic take;
  logic wr;
  logic rdBuf;
  logic tick;
  logic idleFree;
  logic [7:0] status8;
  logic [7:0] control8;
  logic [7:0] wdat;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    tick = (q.cnt == 8'h00);
    idleFree = (q.st == IDLE) && !q.stopReq && !q.rxReq && !q.ackReq;
    take = wbReq.cyc && wbReq.stb && !q.ack;
    wr = take && wbReq.we && wbReq.sel[0];
    rdBuf = take && !wbReq.we && (wbReq.adr == ADDR_BUFFER);
    wdat = wbReq.dat[7:0];
    status8 = 8'h00;
    status8[STA_BF] = q.bf;
    status8[STA_IF] = q.pif;
    status8[STA_ACK_STATUS_BIT] = q.ack_status_bit;
    status8[STA_WRITE_COLLISION_FLAG] = q.write_collision_flag;
    status8[STA_OVF] = q.ovf;
    status8[STA_STOPDET] = q.stopDet;
    control8 = 8'h00;
    control8[CTL_STOP] = q.stopReq;
    control8[CTL_RECV] = q.rxReq;
    control8[CTL_ACKSEQ] = q.ackReq;
    control8[CTL_ACKVAL] = q.ackVal;

    // pins pass two flops before anything looks at them
    d.sclMeta = sclIn;
    d.sclS = q.sclMeta;
    d.sdaMeta = sdaIn;
    d.sdaS = q.sdaMeta;

    // bus slave: one-cycle answer, unmapped reads give zero
    d.ack = take;
    if (take && !wbReq.we) begin
      case (wbReq.adr)
        ADDR_BUFFER: d.rdat = q.xferBuf;
        ADDR_CONTROL: d.rdat = control8;
        ADDR_STATUS: d.rdat = status8;
        ADDR_RATE: d.rdat = q.rate;
        default: d.rdat = 8'h00;
      endcase
    end
    if (rdBuf) begin
      d.bf = 1'b0; // RL14
    end
    // clears come first so that an engine event in the same cycle wins
    if (wr && wbReq.adr == ADDR_STATUS) begin
      if (wdat[STA_IF]) d.pif = 1'b0;
      if (wdat[STA_WRITE_COLLISION_FLAG]) d.write_collision_flag = 1'b0;
      if (wdat[STA_OVF]) d.ovf = 1'b0;
      if (wdat[STA_STOPDET]) d.stopDet = 1'b0;
    end
    if (wr && wbReq.adr == ADDR_RATE) begin
      d.rate = wdat;
    end
    if (wr && wbReq.adr == ADDR_CONTROL) begin
      d.ackVal = wdat[CTL_ACKVAL]; // RL17
      // no queuing: requests are taken only with nothing else going on
      if (idleFree) begin
        d.stopReq = wdat[CTL_STOP];
        d.rxReq = wdat[CTL_RECV] && !wdat[CTL_STOP]; // RL11
        d.ackReq = wdat[CTL_ACKSEQ] && !wdat[CTL_STOP] && !wdat[CTL_RECV];
      end
    end
    if (wr && wbReq.adr == ADDR_BUFFER) begin
      if (!idleFree) begin
        d.write_collision_flag = 1'b1; // RL7
      end else begin
        d.xferBuf = wdat;
        d.shift = wdat; // RL3
        d.bf = 1'b1; // RL1
      end
    end

    // ----------------------------------------------------------------
    // bit engine
    // ----------------------------------------------------------------
    case (q.st)
      IDLE: begin
        d.cnt = q.rate;
        d.bitIdx = 4'h0;
        if (q.sclLow) begin
          d.sdaLow = 1'b0;
        end
        // an unread received byte must not block the next transmit
        if (wr && wbReq.adr == ADDR_BUFFER && idleFree) begin
          d.st = TX_LOW; // RL1
        end else if (q.stopReq) begin
          d.st = STOP_SDA;
        end else if (q.ackReq) begin
          d.st = ACK_LOW;
        end else if (q.rxReq) begin
          d.st = RX_LOW;
        end
      end
      TX_LOW: begin
        d.sclLow = 1'b1;
        // data moves only once the clock is already low
        if (q.sclLow) begin
          d.sdaLow = (q.bitIdx == ACK_BIT) ? 1'b0 : !q.shift[7]; // RL2 RL23
        end
        if (tick && q.sclLow) begin
          d.sclLow = 1'b0; // RL2
          d.cnt = q.rate;
          d.st = TX_HIGH;
        end else if (!tick) begin
          d.cnt = q.cnt - 8'h01;
        end
      end
      TX_HIGH: begin
        if (!q.sclS) begin
          d.cnt = q.rate; // RL22
        end else if (!tick) begin
          d.cnt = q.cnt - 8'h01;
        end else if (q.bitIdx == ACK_BIT) begin
          d.ack_status_bit = q.sdaS; // RL5
          d.pif = 1'b1; // RL6
          d.sclLow = 1'b1;
          d.st = IDLE;
        end else begin
          d.sclLow = 1'b1;
          d.shift = {q.shift[6:0], 1'b0};
          d.bitIdx = q.bitIdx + 4'h1;
          d.cnt = q.rate;
          d.st = TX_LOW;
          if (q.bitIdx == LAST_DATA_BIT) begin
            d.bf = 1'b0; // RL4
          end
        end
      end
      RX_LOW: begin
        d.sclLow = 1'b1;
        d.sdaLow = 1'b0;
        if (tick) begin
          d.sclLow = 1'b0; // RL12
          d.cnt = q.rate;
          d.st = RX_HIGH;
        end else begin
          d.cnt = q.cnt - 8'h01;
        end
      end
      RX_HIGH: begin
        if (!q.sclS) begin
          d.cnt = q.rate; // RL22
        end else if (!tick) begin
          d.cnt = q.cnt - 8'h01;
        end else begin
          d.shift = {q.shift[6:0], q.sdaS}; // RL12 RL23
          d.sclLow = 1'b1;
          d.cnt = q.rate;
          if (q.bitIdx == LAST_DATA_BIT) begin
            // an unread byte is kept; the new one is lost to overflow
            if (d.bf) begin
              d.ovf = 1'b1; // RL15
            end else begin
              d.xferBuf = {q.shift[6:0], q.sdaS}; // RL13
            end
            d.bf = 1'b1; // RL14
            d.pif = 1'b1; // RL13
            d.rxReq = 1'b0;
            d.st = IDLE;
          end else begin
            d.bitIdx = q.bitIdx + 4'h1;
            d.st = RX_LOW;
          end
        end
      end
      ACK_LOW: begin
        d.sclLow = 1'b1;
        if (q.sclLow) begin
          d.sdaLow = !q.ackVal; // RL17 RL18
        end
        if (tick && q.sclLow) begin
          d.sclLow = 1'b0; // RL18
          d.cnt = q.rate;
          d.st = ACK_HIGH;
        end else if (!tick) begin
          d.cnt = q.cnt - 8'h01;
        end
      end
      ACK_HIGH: begin
        if (!q.sclS) begin
          d.cnt = q.rate; // RL22
        end else if (!tick) begin
          d.cnt = q.cnt - 8'h01;
        end else begin
          d.sclLow = 1'b1; // RL18
          d.ackReq = 1'b0; // RL19
          d.pif = 1'b1;
          d.st = IDLE;
        end
      end
      STOP_SDA: begin
        d.sclLow = 1'b1;
        d.sdaLow = 1'b1; // RL20
        d.cnt = q.rate;
        if (q.sdaLow && !q.sdaS) begin
          d.st = STOP_COUNT;
        end
      end
      STOP_COUNT: begin
        if (tick) begin
          d.sclLow = 1'b0; // RL20
          d.cnt = q.rate;
          d.st = STOP_SCLHI;
        end else begin
          d.cnt = q.cnt - 8'h01;
        end
      end
      STOP_SCLHI: begin
        if (!q.sclS) begin
          d.cnt = q.rate; // RL22
        end else if (!tick) begin
          d.cnt = q.cnt - 8'h01;
        end else begin
          d.sdaLow = 1'b0; // RL20
          d.cnt = q.rate;
          d.st = STOP_SDAHI;
        end
      end
      STOP_SDAHI: begin
        d.cnt = q.rate;
        if (q.sdaS && q.sclS) begin
          d.stopDet = 1'b1; // RL21
          d.st = STOP_DONE;
        end
      end
      STOP_DONE: begin
        if (tick) begin
          d.stopReq = 1'b0; // RL10 RL21
          d.pif = 1'b1;
          d.st = IDLE;
        end else begin
          d.cnt = q.cnt - 8'h01;
        end
      end
      default: d.st = IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      q <= '0;
      q.rate <= RATE_RESET;
      q.sclMeta <= 1'b1;
      q.sclS <= 1'b1;
      q.sdaMeta <= 1'b1;
      q.sdaS <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // open drain: only ever pull low
  assign pins.sclOut = 1'b0;
  assign pins.sclOe = q.sclLow;
  assign pins.sdaOut = 1'b0;
  assign pins.sdaOe = q.sdaLow;
  assign wbRsp.ack = q.ack;
  assign wbRsp.dat = {24'h000000, q.rdat};

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  logic bufWr;
  logic hiDone;
  assign bufWr = wr && wbReq.adr == ADDR_BUFFER;
  assign hiDone = tick && q.sclS;

  tx_start_a: assert property ( // RL1
    (bufWr && q.st == IDLE && !q.stopReq && !q.rxReq && !q.ackReq)
      |=> (q.bf && q.st == TX_LOW && q.xferBuf == $past(wdat)))
    else $error("buffer write did not start a transmit");
  sda_stable_a: assert property ( // RL2
    (q.st == TX_HIGH && $past(q.st) == TX_HIGH) |-> $stable(q.sdaLow))
    else $error("data moved while clock released");
  bf_release_a: assert property ( // RL4
    (q.st == TX_HIGH && q.bitIdx == LAST_DATA_BIT && hiDone)
      |=> (!q.bf ##1 !q.sdaLow))
    else $error("eighth falling edge did not clear full and release data");
  ack_status_a: assert property ( // RL5
    (q.st == TX_HIGH && q.bitIdx == ACK_BIT && hiDone)
      |=> (q.ack_status_bit == $past(q.sdaS) && q.pif && q.sclLow && q.st == IDLE))
    else $error("ninth clock result not recorded");
  write_collision_a: assert property ( // RL7
    // a byte landing from the link may change the buffer in that same cycle
    (bufWr && q.st != IDLE && !(q.st == RX_HIGH && hiDone))
      |=> (q.write_collision_flag && $stable(q.xferBuf)))
    else $error("busy buffer write not refused");
  rx_ignore_a: assert property ( // RL11
    (wr && wbReq.adr == ADDR_CONTROL && q.st != IDLE && !q.rxReq) |=> !q.rxReq)
    else $error("receive request taken while busy");
  rx_done_a: assert property ( // RL13
    (q.st == RX_HIGH && q.bitIdx == LAST_DATA_BIT && hiDone)
      |=> (!q.rxReq && q.pif && q.bf && q.sclLow && q.st == IDLE))
    else $error("receive completion wrong");
  buf_read_a: assert property ( // RL14
    (rdBuf && q.st == IDLE) |=> !q.bf)
    else $error("buffer read did not clear full");
  ack_drive_a: assert property ( // RL17
    (q.st == ACK_HIGH) |-> (q.sdaLow == !q.ackVal && !q.sclLow))
    else $error("acknowledge value not on data");
  ack_end_a: assert property ( // RL19
    (q.st == ACK_HIGH && hiDone)
      |=> (!q.ackReq && q.pif && q.sclLow && q.st == IDLE))
    else $error("acknowledge sequence did not finish");
  stop_release_a: assert property ( // RL20
    (q.st == STOP_SCLHI && hiDone)
      |=> (!q.sdaLow && !q.sclLow && q.st == STOP_SDAHI))
    else $error("stop did not release data after clock");
  stop_end_a: assert property ( // RL21
    (q.st == STOP_DONE && tick) |=> (!q.stopReq && q.pif && q.stopDet))
    else $error("stop did not complete");
  rate_reload_a: assert property ( // RL22
    (q.st == TX_HIGH && !q.sclS) |=> (q.cnt == $past(q.rate)))
    else $error("counter ran while clock held low");

  tx_byte_c: cover property (q.st == TX_HIGH && q.bitIdx == ACK_BIT ##1 q.st == IDLE);
  rx_byte_c: cover property (q.st == RX_HIGH ##1 q.st == IDLE && q.bf);
  stop_c: cover property (q.st == STOP_DONE ##1 q.st == IDLE);
  collision_c: cover property (bufWr && q.st != IDLE);
  ack_c: cover property (q.st == ACK_HIGH ##1 q.st == IDLE);

endmodule

`default_nettype wire

// >>> verification/i2c_slave_model.sv
// behavioural addressed device on the two-wire bus
`timescale 1ns/1ps
`default_nettype none
module i2c_slave_model (
  input wire logic scl,
  input wire logic sda,
  input wire logic ack_sequence_request_bit,
  input wire logic sendMode,
  input wire logic [7:0] sendByte,
  output logic sdaLow,
  output logic [7:0] gotByte,
  output logic ackSeen
);
  logic [3:0] cnt = 4'h0;
  logic [3:0] idx = 4'h0;
  logic [7:0] shift = 8'h00;
  logic ackDrive = 1'b0;
  logic sclP = 1'b1;
  logic sdaP = 1'b1;
  initial gotByte = 8'h00;
  initial ackSeen = 1'b1;
  // released line reads high through the pull-up
  assign sdaLow = sendMode ? (idx < 4'h8 && !sendByte[3'h7 - idx[2:0]]) : ackDrive;
  // listening counts rises, not falls: the first byte opens with a lone fall
  always @(scl or sda) begin
    if (scl && !sclP) begin
      if (sendMode) begin
        if (idx == 4'h8) ackSeen = sda;
      end else begin
        if (cnt < 4'h8) shift = {shift[6:0], sda};
        cnt = cnt + 4'h1;
      end
    end else if (!scl && sclP) begin
      if (sendMode) begin
        idx = (idx == 4'h8) ? 4'h0 : idx + 4'h1;
      end else if (cnt == 4'h8) begin
        ackDrive = ack_sequence_request_bit;
      end else if (cnt == 4'h9) begin
        ackDrive = 1'b0;
        cnt = 4'h0;
        gotByte = shift;
      end
    end else if (scl && sda && !sdaP) begin
      // stop seen: frame counters restart
      cnt = 4'h0;
      idx = 4'h0;
    end
    sclP = scl;
    sdaP = sda;
  end
endmodule
`default_nettype wire

// >>> verification/tb_top.sv
// self-checking bench of the two-wire master byte engine
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import i2c_engine_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  wb_req_s wbReq = '0;
  wb_rsp_s wbRsp;
  pin_out_s pins;
  logic slvLow;
  logic ack_sequence_request_bit = 1'b1;
  logic sendMode = 1'b0;
  logic ackSeen;
  logic [7:0] sendByte = 8'h00;
  logic [7:0] gotByte;
  logic sclW;
  logic sdaW;
  logic [31:0] q;
  int mismatches = 0;
  int num_checks = 0;
  assign sclW = pins.sclOe ? pins.sclOut : 1'b1;
  assign sdaW = (pins.sdaOe ? pins.sdaOut : 1'b1) & ~slvLow;
  always #20 clk = ~clk;
  i2c_master_byte_engine i_i2c_master_byte_engine (.clk(clk), .nrst(nrst), .wbReq(wbReq),
    .wbRsp(wbRsp), .sclIn(sclW), .sdaIn(sdaW), .pins(pins));
  i2c_slave_model i_i2c_slave_model (.scl(sclW), .sda(sdaW), .ack_sequence_request_bit(ack_sequence_request_bit),
    .sendMode(sendMode), .sendByte(sendByte), .sdaLow(slvLow), .gotByte(gotByte),
    .ackSeen(ackSeen));
  // ----------------------------------------------------------------
  // bus and check tasks
  // ----------------------------------------------------------------
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wbReq <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'h1, dat: d};
    do @(posedge clk); while (wbRsp.ack !== 1'b1);
    q = wbRsp.dat;
    wbReq <= '0;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    cmp(q & m, e);
  endtask
  // polls the interrupt flag, then clears it before the next command
  task automatic waitIf();
    int n;
    n = 0;
    do begin
      bus(1'b0, ADDR_STATUS, 32'h0);
      n++;
    end while (q[STA_IF] !== 1'b1 && n < 400);
    if (q[STA_IF] !== 1'b1) begin
      mismatches++;
    end
    bus(1'b1, ADDR_STATUS, 32'h02);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    #(40 * 20000);
    mismatches++;
    stop_test();
  end
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    rdChk(ADDR_RATE, 32'hff, 32'h7c);
    rdChk(ADDR_STATUS, 32'h3f, 32'h00);
    rdChk(8'h10, 32'hffffffff, 32'h0);
    bus(1'b1, ADDR_RATE, 32'h02);
    rdChk(ADDR_RATE, 32'hff, 32'h02);
    $display("test registers done");
    bus(1'b1, ADDR_BUFFER, 32'ha5);
    rdChk(ADDR_STATUS, 32'h03, 32'h01);
    bus(1'b1, ADDR_BUFFER, 32'h77);
    bus(1'b1, ADDR_CONTROL, 32'h02);
    waitIf();
    rdChk(ADDR_CONTROL, 32'h07, 32'h00);
    cmp(gotByte, 8'ha5);
    rdChk(ADDR_STATUS, 32'h0d, 32'h08);
    rdChk(ADDR_BUFFER, 32'hff, 32'ha5);
    cmp({sclW, sdaW}, 2'b01);
    bus(1'b1, ADDR_STATUS, 32'h08);
    ack_sequence_request_bit <= 1'b0;
    bus(1'b1, ADDR_BUFFER, 32'h3c);
    waitIf();
    cmp(gotByte, 8'h3c);
    rdChk(ADDR_STATUS, 32'h05, 32'h04);
    $display("test transmit done");
    sendMode <= 1'b1;
    sendByte <= 8'h96;
    bus(1'b1, ADDR_CONTROL, 32'h02);
    bus(1'b1, ADDR_BUFFER, 32'h11);
    waitIf();
    rdChk(ADDR_CONTROL, 32'h07, 32'h00);
    rdChk(ADDR_STATUS, 32'h19, 32'h09);
    rdChk(ADDR_BUFFER, 32'hff, 32'h96);
    rdChk(ADDR_STATUS, 32'h01, 32'h00);
    cmp(sclW, 1'b0);
    bus(1'b1, ADDR_STATUS, 32'h08);
    bus(1'b1, ADDR_CONTROL, 32'h04);
    waitIf();
    cmp(ackSeen, 1'b0);
    rdChk(ADDR_CONTROL, 32'h04, 32'h00);
    sendByte <= 8'h5a;
    bus(1'b1, ADDR_CONTROL, 32'h02);
    bus(1'b1, ADDR_CONTROL, 32'h06);
    waitIf();
    rdChk(ADDR_CONTROL, 32'h07, 32'h00);
    bus(1'b1, ADDR_CONTROL, 32'h0c);
    waitIf();
    cmp(ackSeen, 1'b1);
    sendByte <= 8'hc3;
    bus(1'b1, ADDR_CONTROL, 32'h0a);
    waitIf();
    rdChk(ADDR_STATUS, 32'h11, 32'h11);
    rdChk(ADDR_BUFFER, 32'hff, 32'h5a);
    $display("test receive done");
    sendMode <= 1'b0;
    bus(1'b1, ADDR_STATUS, 32'h18);
    bus(1'b1, ADDR_CONTROL, 32'h01);
    bus(1'b1, ADDR_BUFFER, 32'h22);
    waitIf();
    rdChk(ADDR_CONTROL, 32'h01, 32'h00);
    rdChk(ADDR_STATUS, 32'h38, 32'h28);
    cmp({sclW, sdaW}, 2'b11);
    $display("test stop done");
    stop_test();
  end
endmodule
`default_nettype wire
